// File: verilog/fprom_ctrl.sv
// Controller that reads and programs a 1024 x 4 fuse PROM over its pins.
//
// Contract
// - Apply nominal supply, then drive the address, before enabling.
// - Enable programming by driving a chip select high.
// - Pulse only the target output; leave the others open.
// - After a pulse: remove it, lower supply, select low, verify zero.
// - Repeat the whole sequence for each further bit.
// - Pulse width lies within limits, recommended width used.
// - Space pulses to about twenty percent duty.
// - Allow up to eight pulse and verify passes per bit.
// - Drive every address line during programming, never float.
`timescale 1ns/1ps
`default_nettype none
`include "fprom_consts.svh"
module fprom_ctrl
    import fprom_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    // User side.
    input  wire logic                     rd_req,
    input  wire logic                     prog_req,
    input  wire logic [`FPROM_ADDR_W-1:0] req_addr,
    input  wire logic [1:0]               req_bit,
    output logic                          busy,
    output logic                          done,
    output logic [`FPROM_DATA_W-1:0]      rd_data,
    output logic                          prog_fail,
    output logic [3:0]                    pulses_used,
    // Device side.
    output logic [`FPROM_ADDR_W-1:0]      word_address_lines,
    output logic                          select_first_n,
    output logic                          select_second_n,
    input  wire logic [`FPROM_DATA_W-1:0] word_outputs_in,
    output logic [`FPROM_DATA_W-1:0]      burn_pulse_oe,
    output logic                          supply_on,
    output logic                          supply_low_verify
);
    typedef struct packed {
        fprom_state_t                    st;
        logic [`FPROM_CNT_W-1:0]         cnt;
        logic [3:0]                      pulses;
        logic [1:0]                      bit_sel;
        logic [`FPROM_ADDR_W-1:0]        addr;
        logic                            cs1_n;
        logic                            cs2_n;
        logic [`FPROM_DATA_W-1:0]        oe;
        logic                            sup_on;
        logic                            sup_low;
        logic                            busy;
        logic                            done;
        logic                            fail;
        logic [`FPROM_DATA_W-1:0]        data;
    } fprom_regs_t;

    fprom_regs_t s_r;
    fprom_regs_t s_nxt;
    logic [`FPROM_DATA_W-1:0] pins_sync;

    // Device outputs come from another timing world, so resample them.
    fprom_sync #(.W(`FPROM_DATA_W)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (word_outputs_in),
        .q     (pins_sync)
    );

    // Sequencer for reads and the burn, verify loop.
    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        if (s_r.cnt != '0)
            s_nxt.cnt = s_r.cnt - 1'b1;
        case (s_r.st)
            FPROM_IDLE: begin
                s_nxt.oe = '0;
                if (prog_req) begin
                    s_nxt.st      = FPROM_SETUP;
                    s_nxt.addr    = req_addr;
                    s_nxt.bit_sel = req_bit;
                    s_nxt.pulses  = '0;
                    s_nxt.fail    = 1'b0;
                    s_nxt.sup_on  = 1'b1;
                    s_nxt.sup_low = 1'b0;
                    s_nxt.cs1_n   = 1'b0;
                    s_nxt.cs2_n   = 1'b0;
                    s_nxt.busy    = 1'b1;
                    s_nxt.cnt     = `FPROM_CNT_W'(`FPROM_SETTLE_CYC);
                end else if (rd_req) begin
                    s_nxt.st      = FPROM_RD;
                    s_nxt.addr    = req_addr;
                    s_nxt.sup_on  = 1'b1;
                    s_nxt.sup_low = 1'b0;
                    s_nxt.cs1_n   = 1'b0;
                    s_nxt.cs2_n   = 1'b0;
                    s_nxt.busy    = 1'b1;
                    // Access delay plus the two synchroniser stages.
                    s_nxt.cnt     = `FPROM_CNT_W'(`FPROM_READ_CYC);
                end
            end
            FPROM_RD: begin
                if (s_r.cnt == '0) begin
                    s_nxt.data = pins_sync;
                    s_nxt.st   = FPROM_DONE;
                end
            end
            FPROM_SETUP: begin
                // Supply and address are stable before the enable.
                if (s_r.cnt == '0) begin
                    s_nxt.st    = FPROM_ENABLE;
                    s_nxt.cs1_n = 1'b1;
                    s_nxt.cs2_n = 1'b1;
                    s_nxt.cnt   = `FPROM_CNT_W'(`FPROM_SETTLE_CYC);
                end
            end
            FPROM_ENABLE: begin
                if (s_r.cnt == '0) begin
                    s_nxt.st  = FPROM_PULSE;
                    s_nxt.oe  = `FPROM_DATA_W'(1) << s_r.bit_sel;
                    // The state leaves one edge after the count hits zero,
                    // so load one less to keep the pulse at its nominal width.
                    s_nxt.cnt = `FPROM_CNT_W'(`FPROM_PULSE_CYC - 1);
                    s_nxt.pulses = s_r.pulses + 4'h1;
                end
            end
            FPROM_PULSE: begin
                if (s_r.cnt == '0) begin
                    s_nxt.oe      = '0;
                    s_nxt.sup_low = 1'b1;
                    s_nxt.st      = FPROM_LOWV;
                    s_nxt.cnt     = `FPROM_CNT_W'(`FPROM_SETTLE_CYC);
                end
            end
            FPROM_LOWV: begin
                if (s_r.cnt == '0) begin
                    s_nxt.cs1_n = 1'b0;
                    s_nxt.cs2_n = 1'b0;
                    s_nxt.st    = FPROM_VERIFY;
                    s_nxt.cnt   = `FPROM_CNT_W'(`FPROM_READ_CYC);
                end
            end
            FPROM_VERIFY: begin
                if (s_r.cnt == '0) begin
                    s_nxt.data = pins_sync;
                    if (!pins_sync[s_r.bit_sel]) begin
                        s_nxt.st = FPROM_DONE;
                    end else if (s_r.pulses >= `FPROM_MAX_PULSES) begin
                        s_nxt.fail = 1'b1;
                        s_nxt.st   = FPROM_DONE;
                    end else begin
                        // Rest keeps duty near twenty percent.
                        s_nxt.sup_low = 1'b0;
                        s_nxt.st  = FPROM_REST;
                        s_nxt.cnt = `FPROM_CNT_W'(`FPROM_REST_CYC);
                    end
                end
            end
            FPROM_REST: begin
                if (s_r.cnt == '0) begin
                    s_nxt.cs1_n = 1'b1;
                    s_nxt.cs2_n = 1'b1;
                    s_nxt.st    = FPROM_ENABLE;
                    s_nxt.cnt   = `FPROM_CNT_W'(`FPROM_SETTLE_CYC);
                end
            end
            FPROM_DONE: begin
                // Deselect and power down; address stays driven.
                s_nxt.cs1_n   = 1'b1;
                s_nxt.cs2_n   = 1'b1;
                s_nxt.sup_on  = 1'b0;
                s_nxt.sup_low = 1'b0;
                s_nxt.busy    = 1'b0;
                s_nxt.done    = 1'b1;
                s_nxt.st      = FPROM_IDLE;
            end
            default: begin
                s_nxt.st = FPROM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r         <= '0;
            s_r.st      <= FPROM_IDLE;
            s_r.cs1_n   <= 1'b1;
            s_r.cs2_n   <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Every output is a flip-flop of the state record.
    assign busy               = s_r.busy;
    assign done               = s_r.done;
    assign rd_data            = s_r.data;
    assign prog_fail          = s_r.fail;
    assign pulses_used        = s_r.pulses;
    assign word_address_lines = s_r.addr;
    assign select_first_n     = s_r.cs1_n;
    assign select_second_n    = s_r.cs2_n;
    assign burn_pulse_oe      = s_r.oe;
    assign supply_on          = s_r.sup_on;
    assign supply_low_verify  = s_r.sup_low;
endmodule // fprom_ctrl
`default_nettype wire

// File: verilog/fprom_consts.svh
// Constants for the fuse PROM read and program controller.
`ifndef FPROM_CONSTS_SVH
`define FPROM_CONSTS_SVH
`define FPROM_ADDR_W        10
`define FPROM_DATA_W        4
`define FPROM_CLK_MHZ       50
// Address access allowance in ns, settle before sampling a read.
`define FPROM_ACCESS_NS     60
`define FPROM_ACCESS_CYC    ((`FPROM_ACCESS_NS*`FPROM_CLK_MHZ+999)/1000)
// Flip-flops between the device pins and the sampling logic.
`define FPROM_SYNC_STAGES   2
// Wait before a read or verify sample: access plus synchroniser delay.
`define FPROM_READ_CYC      (`FPROM_ACCESS_CYC+`FPROM_SYNC_STAGES)
// Recommended burn pulse width in us (0.18 ms).
`define FPROM_PULSE_US      180
`define FPROM_PULSE_CYC     (`FPROM_PULSE_US*`FPROM_CLK_MHZ)
// Twenty percent duty: off time is four pulse widths.
`define FPROM_REST_CYC      (4*`FPROM_PULSE_CYC)
// Supply settle time in us after a change of level.
`define FPROM_SETTLE_US     10
`define FPROM_SETTLE_CYC    (`FPROM_SETTLE_US*`FPROM_CLK_MHZ)
`define FPROM_MAX_PULSES    4'h8
`define FPROM_CNT_W         20
`endif

// File: verilog/fprom_pkg.sv
// Types for the fuse PROM read and program controller.
`default_nettype none
package fprom_pkg;
    typedef enum logic [8:0] {
        FPROM_IDLE   = 9'h001,
        FPROM_RD     = 9'h002,
        FPROM_SETUP  = 9'h004,
        FPROM_ENABLE = 9'h008,
        FPROM_PULSE  = 9'h010,
        FPROM_LOWV   = 9'h020,
        FPROM_VERIFY = 9'h040,
        FPROM_REST   = 9'h080,
        FPROM_DONE   = 9'h100
    } fprom_state_t;
endpackage
`default_nettype wire

// File: verilog/fprom_sync.sv
// Two flip-flop synchroniser for the PROM output pins.
`timescale 1ns/1ps
`default_nettype none
module fprom_sync #(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // fprom_sync
`default_nettype wire

// File: tb/fprom_dev_model.sv
// Behavioural 1024 x 4 fuse PROM that answers the controller's pins.
`timescale 1ns/1ps
`default_nettype none
module fprom_dev_model (
    input  wire logic       clk,
    input  wire logic [9:0] addr,
    input  wire logic       sel1_n,
    input  wire logic       sel2_n,
    input  wire logic [3:0] burn,
    input  wire logic       pwr,
    input  wire logic [3:0] need,
    output wire logic [3:0] dout
);
    logic [3:0] mem [1024];
    logic [3:0] last_r = 4'hF;
    logic [3:0] burn_q = 4'h0;
    logic [3:0] hits = 4'h0;
    wire        sel = !sel1_n && !sel2_n && pwr;
    // A blank part reads one on every bit of every word.
    initial foreach (mem[i]) mem[i] = 4'hF;
    // A fuse opens after the set number of ended pulses and never heals.
    always @(posedge clk) begin
        burn_q <= burn;
        if (sel) last_r <= mem[addr];
        if ((burn_q & ~burn) != 4'h0 && (sel1_n || sel2_n) && pwr) begin
            hits = hits + 4'h1;
            if (hits >= need) begin
                mem[addr] <= mem[addr] & ~burn_q;
                hits = 4'h0;
            end
        end
    end
    // Deselected outputs float, so show the inverse rather than stale data.
    assign #40 dout = sel ? mem[addr] : ~last_r;
endmodule  // fprom_dev_model
`default_nettype wire

// File: tb/fprom_ctrl_monitor.sv
// Checker of the PROM controller's pin sequencing and handshake.
`timescale 1ns/1ps
`default_nettype none
module fprom_ctrl_monitor (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       rd_req,
    input wire logic       prog_req,
    input wire logic       busy,
    input wire logic       done,
    input wire logic [9:0] word_address_lines,
    input wire logic       select_first_n,
    input wire logic       select_second_n,
    input wire logic [3:0] burn_pulse_oe,
    input wire logic       supply_on,
    input wire logic       supply_low_verify
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [15:0] width_r;
    // Counts how long the current burn pulse has stood.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) width_r <= 16'h0000;
        else width_r <= (|burn_pulse_oe) ? width_r + 16'h0001 : 16'h0000;
    end
    property p_done_idle; done |-> !busy; endproperty
    a_done_idle: assert property (p_done_idle) else $error("done while busy");
    property p_done_pulse; done |=> !done; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done too long");
    property p_read_lat; rd_req && !prog_req && !busy && !done |-> ##8 done;
    endproperty
    a_read_lat: assert property (p_read_lat) else $error("read late");
    property p_addr_hold; busy && !done |=> $stable(word_address_lines);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("addr moved");
    property p_one_hot; |burn_pulse_oe |-> $onehot(burn_pulse_oe); endproperty
    a_one_hot: assert property (p_one_hot)
        else $error("pulse on many");
    property p_pulse_en; |burn_pulse_oe |-> supply_on && !supply_low_verify
        && (select_first_n || select_second_n); endproperty
    a_pulse_en: assert property (p_pulse_en)
        else $error("bad enable");
    property p_verify; supply_low_verify |-> burn_pulse_oe == 4'h0; endproperty
    a_verify: assert property (p_verify)
        else $error("pulse in verify");
    property p_width; $fell(|burn_pulse_oe) |-> width_r == 16'h2328; endproperty
    a_width: assert property (p_width) else $error("pulse width");
    c_read: cover property (rd_req && !busy ##8 done);
    c_pulse: cover property ($fell(|burn_pulse_oe));
    c_verify: cover property (supply_low_verify && !select_first_n);
endmodule  // fprom_ctrl_monitor
bind fprom_ctrl fprom_ctrl_monitor u_mon (.clk(clk), .rst_n(rst_n),
    .rd_req(rd_req), .prog_req(prog_req), .busy(busy), .done(done),
    .word_address_lines(word_address_lines), .select_first_n(select_first_n),
    .select_second_n(select_second_n), .burn_pulse_oe(burn_pulse_oe),
    .supply_on(supply_on), .supply_low_verify(supply_low_verify));
`default_nettype wire

// File: tb/fprom_ctrl_bench.sv
// Self-checking bench for the fuse PROM read and program controller.
`timescale 1ns/1ps
`default_nettype none
module fprom_ctrl_bench;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       rd_req = 1'b0;
    logic       prog_req = 1'b0;
    logic [9:0] req_addr = 10'h000;
    logic [1:0] req_bit = 2'h0;
    logic [3:0] need = 4'h1;
    logic       busy, done, fail, s1_n, s2_n, pwr, lowv;
    logic [3:0] rd_data, used, oe;
    logic [9:0] wa;
    wire  logic [3:0] dq;
    int         bad_count = 0;
    int         tests_run = 0;
    int         cycles = 0;
    fprom_ctrl dut (.clk(clk), .rst_n(rst_n), .rd_req(rd_req),
        .prog_req(prog_req), .req_addr(req_addr), .req_bit(req_bit),
        .busy(busy), .done(done), .rd_data(rd_data), .prog_fail(fail),
        .pulses_used(used), .word_address_lines(wa), .select_first_n(s1_n),
        .select_second_n(s2_n), .word_outputs_in(dq), .burn_pulse_oe(oe),
        .supply_on(pwr), .supply_low_verify(lowv));
    fprom_dev_model prom (.clk(clk), .addr(wa), .sel1_n(s1_n), .sel2_n(s2_n),
        .burn(oe), .pwr(pwr), .need(need), .dout(dq));
    // Free-running 50 MHz clock.
    initial forever #10 clk = ~clk;
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Cuts a hang short well past the longest expected run.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 99000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Issues one request for a cycle and waits for done under a bound.
    task automatic issue(input logic prog, input logic [9:0] a,
                         input logic [1:0] b, output int n);
        @(negedge clk);
        req_addr = a;
        req_bit = b;
        rd_req = !prog;
        prog_req = prog;
        @(negedge clk);
        rd_req = 1'b0;
        prog_req = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 60000) begin
            @(negedge clk);
            n++;
        end
        check({3'h0, done}, 4'h1);
    endtask
    task automatic do_read(input logic [9:0] a, input logic [3:0] exp);
        int n;
        issue(1'b0, a, 2'h0, n);
        // Done shows in the eighth cycle after the take, which is the
        // seventh falling edge after the request is dropped.
        check(4'(n), 4'h7);
        check(rd_data, exp);
    endtask
    task automatic do_prog(input logic [9:0] a, input logic [1:0] b,
                           input logic [3:0] nd);
        int n;
        need = nd;
        issue(1'b1, a, b, n);
        check({3'h0, fail}, 4'h0);
        check(used, nd);
    endtask
    // Blank part reads all ones at both ends of the address range.
    task automatic t_blank();
        do_read(10'h000, 4'hF);
        do_read(10'h3FF, 4'hF);
    endtask
    // One pulse opens a bit; neighbours stay untouched.
    task automatic t_burn_once();
        do_prog(10'h155, 2'h2, 4'h1);
        do_read(10'h155, 4'hB);
        do_read(10'h154, 4'hF);
    endtask
    // A stubborn bit needs a second pass, then a further bit in that word.
    task automatic t_burn_twice();
        do_prog(10'h2AA, 2'h0, 4'h2);
        do_prog(10'h2AA, 2'h3, 4'h1);
        do_read(10'h2AA, 4'h6);
    endtask
    // Reset, then the scenarios in turn.
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        t_blank();
        t_burn_once();
        t_burn_twice();
        end_of_test();
    end
endmodule  // fprom_ctrl_bench
`default_nettype wire
